// File: hw/shp_device.sv
// device end of the serial host register port
`timescale 1ns/100ps
`default_nettype none
module shp_device (
	// system
	input wire logic clk_sys,
	input wire logic resetn,
	// serial link
	shp_if.dev link,
	// board strap
	input wire logic host_port_select,
	// register file side
	input wire logic [7:0] reg_rd_data,
	output logic reg_wr_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wr_data,
	output logic cfg_default,
	output logic serial_active
);

	// ==========================================
	// pin synchronisers
	logic [shp_pkg::SYNC_W-1:0] pins;
	logic [shp_pkg::SYNC_W-1:0] sync1_reg;
	logic [shp_pkg::SYNC_W-1:0] sync2_reg;
	logic sclk_d_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_high;
	logic rst_pin_low;

	assign pins = {link.rst_n_pin, host_port_select, link.sdi, link.sclk,
		link.cs_n};

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= shp_pkg::SYNC_IDLE;
			sync2_reg <= shp_pkg::SYNC_IDLE;
			sclk_d_reg <= 1'b0;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			sclk_d_reg <= sync2_reg[shp_pkg::SI_SCLK];
		end
	end

	// edges seen in the system clock; the host clock must stay slow enough
	assign sclk_rise = sync2_reg[shp_pkg::SI_SCLK] & ~sclk_d_reg;
	assign sclk_fall = ~sync2_reg[shp_pkg::SI_SCLK] & sclk_d_reg;
	assign cs_high = sync2_reg[shp_pkg::SI_CS];
	assign rst_pin_low = ~sync2_reg[shp_pkg::SI_RST];

	// ==========================================
	// frame engine state
	shp_pkg::shp_dev_state_t state_reg, state_next;
	logic [shp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [shp_pkg::FRAME_BITS-1:0] sh_reg, sh_next;
	logic rw_reg, rw_next;
	logic [shp_pkg::DATA_W-2:0] rd_sh_reg, rd_sh_next;
	logic sdo_reg, sdo_next;
	logic sdo_oe_reg, sdo_oe_next;
	logic wr_en_reg, wr_en_next;
	logic [shp_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [shp_pkg::DATA_W-1:0] wdata_reg, wdata_next;
	logic [shp_pkg::RST_CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
	logic cfg_def_reg, cfg_def_next;
	logic [1:0] strap_age_reg, strap_age_next;
	logic serial_reg, serial_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		rw_next = rw_reg;
		rd_sh_next = rd_sh_reg;
		sdo_next = sdo_reg;
		sdo_oe_next = sdo_oe_reg;
		wr_en_next = 1'b0;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rst_cnt_next = rst_cnt_reg;
		cfg_def_next = cfg_def_reg;
		strap_age_next = strap_age_reg;
		serial_next = serial_reg;

		// strap taken once the synchroniser has filled after reset
		if (strap_age_reg != shp_pkg::STRAP_SETTLE) begin
			strap_age_next = strap_age_reg + 2'h1;
			serial_next = sync2_reg[shp_pkg::SI_STRAP];
		end

		// defaults only after the pin has stayed low past the minimum
		if (rst_pin_low) begin
			if (rst_cnt_reg != shp_pkg::RESET_MIN_CNT) begin
				rst_cnt_next = rst_cnt_reg + 11'h001;
			end else begin
				cfg_def_next = 1'b1;
			end
		end else begin
			rst_cnt_next = '0;
			cfg_def_next = 1'b0;
		end

		if (!serial_reg || rst_pin_low) begin
			// parallel mode or pin reset: link is ignored entirely
			state_next = shp_pkg::DV_IDLE;
			cnt_next = '0;
			sdo_oe_next = 1'b0;
		end else if (cs_high) begin
			// only a full write frame commits, at the chip select rise
			if (state_reg == shp_pkg::DV_HOLD && rw_reg == shp_pkg::RW_WRITE) begin
				wr_en_next = 1'b1;
				addr_next = sh_reg[shp_pkg::POS_ADDR +: shp_pkg::ADDR_W];
				wdata_next = sh_reg[shp_pkg::POS_DATA +: shp_pkg::DATA_W];
			end
			state_next = shp_pkg::DV_IDLE;
			cnt_next = '0;
			sdo_oe_next = 1'b0;
		end else begin
			unique case (state_reg)
				shp_pkg::DV_IDLE, shp_pkg::DV_SHIFT: begin
					state_next = shp_pkg::DV_SHIFT;
					if (sclk_rise) begin
						// lsb first: each new bit enters at the top
						sh_next = {sync2_reg[shp_pkg::SI_SDI],
							sh_reg[shp_pkg::FRAME_BITS-1:1]};
						cnt_next = cnt_reg + 5'h01;
						if (cnt_next == shp_pkg::CYC_DUMMY_LAST) begin
							// dummy bits are shifted through and never read
							addr_next = sh_next[shp_pkg::POS16_ADDR +:
								shp_pkg::ADDR_W];
							rw_next = sh_next[shp_pkg::POS16_RW];
						end
						if (cnt_next == shp_pkg::CYC_LAST) begin
							state_next = shp_pkg::DV_HOLD;
						end
					end
				end
				shp_pkg::DV_HOLD: begin
					// clock rises beyond the 24th are ignored
					state_next = shp_pkg::DV_HOLD;
				end
				default: begin
					state_next = shp_pkg::DV_IDLE;
					cnt_next = '0;
				end
			endcase

			// read data phase, driven from the falling edges
			if (sclk_fall && rw_reg == shp_pkg::RW_READ &&
				cnt_reg >= shp_pkg::CYC_DATA_FIRST) begin
				sdo_oe_next = 1'b1;
				if (cnt_reg == shp_pkg::CYC_DATA_FIRST) begin
					sdo_next = reg_rd_data[0];
					rd_sh_next = reg_rd_data[shp_pkg::DATA_W-1:1];
				end else begin
					sdo_next = rd_sh_reg[0];
					rd_sh_next = {1'b0, rd_sh_reg[shp_pkg::DATA_W-2:1]};
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= shp_pkg::DV_IDLE;
			cnt_reg <= '0;
			sh_reg <= '0;
			rw_reg <= shp_pkg::RW_WRITE;
			rd_sh_reg <= '0;
			sdo_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
			wr_en_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			rst_cnt_reg <= '0;
			cfg_def_reg <= 1'b0;
			strap_age_reg <= 2'h0;
			serial_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			rw_reg <= rw_next;
			rd_sh_reg <= rd_sh_next;
			sdo_reg <= sdo_next;
			sdo_oe_reg <= sdo_oe_next;
			wr_en_reg <= wr_en_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rst_cnt_reg <= rst_cnt_next;
			cfg_def_reg <= cfg_def_next;
			strap_age_reg <= strap_age_next;
			serial_reg <= serial_next;
		end
	end

	// ==========================================
	// outputs
	assign link.sdo_out = sdo_reg;
	assign link.sdo_oe = sdo_oe_reg;
	assign reg_wr_en = wr_en_reg;
	assign reg_addr = addr_reg;
	assign reg_wr_data = wdata_reg;
	assign cfg_default = cfg_def_reg;
	assign serial_active = serial_reg;

endmodule
`default_nettype wire

// File: hw/shp_pkg.sv
// shared constants and state types for the serial host register port
package shp_pkg;

	// ==========================================
	// clocking and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int RESET_MIN_NS = 10000;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_MARGIN_CYC = 16;
	localparam int RST_CNT_W = 11;
	localparam logic [RST_CNT_W-1:0] RESET_MIN_CNT = RST_CNT_W'(RESET_MIN_CYC);
	localparam logic [RST_CNT_W-1:0] RESET_HOLD_CNT =
		RST_CNT_W'(RESET_MIN_CYC + RESET_MARGIN_CYC);
	// host serial clock half period, kept well above the 20 ns minimum
	localparam int SCLK_HALF_NS = 80;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYC - 1);

	// ==========================================
	// frame layout
	localparam int FRAME_BITS = 24;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DUMMY_BITS = 7;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CYC_DUMMY_LAST = 5'h10;
	localparam logic [CNT_W-1:0] CYC_DATA_FIRST = 5'h11;
	localparam logic [CNT_W-1:0] CYC_LAST = 5'h18;
	// positions in the shift register after all 24 bits
	localparam int POS_ADDR = 0;
	localparam int POS_RW = 8;
	localparam int POS_DATA = 16;
	// positions after 16 bits have been shifted in
	localparam int POS16_ADDR = 8;
	localparam int POS16_RW = 16;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;

	// ==========================================
	// synchroniser lanes on the device side
	localparam int SYNC_W = 5;
	localparam int SI_CS = 0;
	localparam int SI_SCLK = 1;
	localparam int SI_SDI = 2;
	localparam int SI_STRAP = 3;
	localparam int SI_RST = 4;
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h11;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ==========================================
	// state machines
	typedef enum logic [2:0] {
		DV_IDLE = 3'h1,
		DV_SHIFT = 3'h2,
		DV_HOLD = 3'h4
	} shp_dev_state_t;

	typedef enum logic [4:0] {
		HS_IDLE = 5'h01,
		HS_RESET = 5'h02,
		HS_PRE = 5'h04,
		HS_SHIFT = 5'h08,
		HS_POST = 5'h10
	} shp_host_state_t;

endpackage

// File: hw/shp_if.sv
// serial link between host and device ends
`timescale 1ns/100ps
`default_nettype none
interface shp_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic rst_n_pin;
	logic sdo_out;
	logic sdo_oe;
	wire sdo;

	// board pull-up: the line reads high whenever the device lets go
	assign sdo = sdo_oe ? sdo_out : 1'b1;

	modport dev (
		input cs_n,
		input sclk,
		input sdi,
		input rst_n_pin,
		output sdo_out,
		output sdo_oe
	);

	modport host (
		output cs_n,
		output sclk,
		output sdi,
		output rst_n_pin,
		input sdo
	);
endinterface
`default_nettype wire

// File: hw/shp_host.sv
// host end of the serial host register port
`timescale 1ns/100ps
`default_nettype none
module shp_host (
	// system
	input wire logic clk_sys,
	input wire logic resetn,
	// serial link
	shp_if.host link,
	// commands
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic rst_req,
	output logic cmd_ready,
	// answers
	output logic rsp_valid,
	output logic [7:0] rsp_rdata
);

	// ==========================================
	// returned data synchroniser and clock divider
	logic sdo1_reg;
	logic sdo2_reg;
	logic [shp_pkg::DIV_W-1:0] div_reg;
	logic tick;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sdo1_reg <= 1'b0;
			sdo2_reg <= 1'b0;
			div_reg <= '0;
		end else begin
			sdo1_reg <= link.sdo;
			sdo2_reg <= sdo1_reg;
			div_reg <= tick ? '0 : div_reg + 4'h1;
		end
	end

	assign tick = (div_reg == shp_pkg::DIV_LAST);

	// ==========================================
	// transfer sequencer
	shp_pkg::shp_host_state_t state_reg, state_next;
	logic sclk_reg, sclk_next;
	logic cs_n_reg, cs_n_next;
	logic sdi_reg, sdi_next;
	logic rst_pin_reg, rst_pin_next;
	logic [shp_pkg::FRAME_BITS-1:0] frame_reg, frame_next;
	logic rw_reg, rw_next;
	logic [shp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic [shp_pkg::DATA_W-1:0] rx_reg, rx_next;
	logic rsp_valid_reg, rsp_valid_next;
	logic [shp_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic ready_reg, ready_next;
	logic [shp_pkg::RST_CNT_W-1:0] rst_cnt_reg, rst_cnt_next;

	always_comb begin
		state_next = state_reg;
		sclk_next = sclk_reg;
		cs_n_next = cs_n_reg;
		sdi_next = sdi_reg;
		rst_pin_next = rst_pin_reg;
		frame_next = frame_reg;
		rw_next = rw_reg;
		cnt_next = cnt_reg;
		rx_next = rx_reg;
		rsp_valid_next = 1'b0;
		rdata_next = rdata_reg;
		ready_next = ready_reg;
		rst_cnt_next = rst_cnt_reg;

		unique case (state_reg)
			shp_pkg::HS_IDLE: begin
				if (rst_req) begin
					rst_pin_next = 1'b0;
					rst_cnt_next = '0;
					ready_next = 1'b0;
					state_next = shp_pkg::HS_RESET;
				end else if (cmd_valid) begin
					// address, direction, dummies, data; all lsb first
					rw_next = cmd_write ? shp_pkg::RW_WRITE : shp_pkg::RW_READ;
					frame_next = {cmd_wdata, {shp_pkg::DUMMY_BITS{1'b0}},
						rw_next, cmd_addr};
					rx_next = '0;
					ready_next = 1'b0;
					state_next = shp_pkg::HS_PRE;
				end
			end
			shp_pkg::HS_RESET: begin
				// held past the device minimum with some margin
				rst_cnt_next = rst_cnt_reg + 11'h001;
				if (rst_cnt_reg == shp_pkg::RESET_HOLD_CNT) begin
					rst_pin_next = 1'b1;
					ready_next = 1'b1;
					state_next = shp_pkg::HS_IDLE;
				end
			end
			shp_pkg::HS_PRE: begin
				// one full clock pulse with select high, then select
				if (tick) begin
					if (!sclk_reg) begin
						sclk_next = 1'b1;
					end else begin
						sclk_next = 1'b0;
						cs_n_next = 1'b0;
						sdi_next = frame_reg[0];
						cnt_next = '0;
						state_next = shp_pkg::HS_SHIFT;
					end
				end
			end
			shp_pkg::HS_SHIFT: begin
				if (tick) begin
					if (!sclk_reg) begin
						// read bit sampled late in the low phase
						if (rw_reg == shp_pkg::RW_READ &&
							cnt_reg >= shp_pkg::CYC_DATA_FIRST) begin
							rx_next = {sdo2_reg, rx_reg[shp_pkg::DATA_W-1:1]};
						end
						if (cnt_reg == shp_pkg::CYC_LAST) begin
							cs_n_next = 1'b1;
							sdi_next = 1'b0;
							state_next = shp_pkg::HS_POST;
						end else begin
							sclk_next = 1'b1;
						end
					end else begin
						sclk_next = 1'b0;
						cnt_next = cnt_reg + 5'h01;
						frame_next = {1'b0, frame_reg[shp_pkg::FRAME_BITS-1:1]};
						sdi_next = frame_reg[1];
					end
				end
			end
			shp_pkg::HS_POST: begin
				// select stays high at least one half period
				if (tick) begin
					rsp_valid_next = 1'b1;
					rdata_next = (rw_reg == shp_pkg::RW_READ) ? rx_reg : '0;
					ready_next = 1'b1;
					state_next = shp_pkg::HS_IDLE;
				end
			end
			default: begin
				state_next = shp_pkg::HS_IDLE;
				ready_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= shp_pkg::HS_IDLE;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			sdi_reg <= 1'b0;
			rst_pin_reg <= 1'b1;
			frame_reg <= '0;
			rw_reg <= shp_pkg::RW_WRITE;
			cnt_reg <= '0;
			rx_reg <= '0;
			rsp_valid_reg <= 1'b0;
			rdata_reg <= '0;
			ready_reg <= 1'b1;
			rst_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			sclk_reg <= sclk_next;
			cs_n_reg <= cs_n_next;
			sdi_reg <= sdi_next;
			rst_pin_reg <= rst_pin_next;
			frame_reg <= frame_next;
			rw_reg <= rw_next;
			cnt_reg <= cnt_next;
			rx_reg <= rx_next;
			rsp_valid_reg <= rsp_valid_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			rst_cnt_reg <= rst_cnt_next;
		end
	end

	// ==========================================
	// outputs
	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.sdi = sdi_reg;
	assign link.rst_n_pin = rst_pin_reg;
	assign cmd_ready = ready_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_rdata = rdata_reg;

endmodule
`default_nettype wire

// File: verif/shp_link_sva.sv
// concurrent checks on the serial link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module shp_link_sva (
	// system
	input wire logic clk_sys,
	input wire logic resetn,
	// link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic rst_n_pin,
	input wire logic sdo_out,
	input wire logic sdo_oe
);
	// ==========================================
	// helper counters
	logic sclk_q_reg;
	logic rise;
	logic rw_reg, rw_next;
	logic [4:0] rise_reg, rise_next;
	logic [10:0] low_reg, low_next;

	always_comb begin
		rise = sclk && !sclk_q_reg && !cs_n;
		rise_next = cs_n ? 5'h00 : rise_reg + {4'h0, rise};
		rw_next = (rise && rise_reg == 5'h08) ? sdi : rw_reg;
		// saturates so a long pin reset cannot wrap
		low_next = rst_n_pin ? 11'h000 : low_reg + {10'h000, low_reg != 11'h7ff};
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sclk_q_reg <= 1'b0;
			rise_reg <= 5'h00;
			rw_reg <= 1'b0;
			low_reg <= 11'h000;
		end else begin
			sclk_q_reg <= sclk;
			rise_reg <= rise_next;
			rw_reg <= rw_next;
			low_reg <= low_next;
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	frame_length_a:
	assert property ($rose(cs_n) |-> rise_reg == 5'h18)
		else $error("frame closed without 24 clock rises");
	select_pulse_a:
	assert property ($fell(cs_n) |-> $fell(sclk))
		else $error("select without a preceding clock pulse");
	data_setup_a:
	assert property ($rose(sclk) && !cs_n |-> $stable(sdi))
		else $error("data in moved at the sampling rise");
	read_only_out_a:
	assert property (sdo_oe |-> rw_reg)
		else $error("data out driven in a write frame");
	out_start_a:
	assert property ($rose(sdo_oe) |-> rise_reg == 5'h11 && !sclk && !$past(sclk, 3))
		else $error("read data did not start after fall 17");
	out_change_a:
	assert property ($changed(sdo_out) && sdo_oe && $past(sdo_oe)
		|-> !sclk && rise_reg > 5'h11 && !cs_n)
		else $error("read bit changed outside a clock low phase");
	out_release_a:
	assert property ($rose(cs_n) |-> ##[0:4] !sdo_oe)
		else $error("data out not released after deselect");
	idle_float_a:
	assert property (cs_n [*8] |-> !sdo_oe)
		else $error("data out driven while deselected");
	reset_hold_a:
	assert property ($rose(rst_n_pin) |-> low_reg >= 11'h4e2)
		else $error("reset pin pulse shorter than 1250 cycles");
endmodule
`default_nettype wire

// File: verif/serial_host_register_port_tb.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/100ps
`default_nettype none
module serial_host_register_port_tb;
	logic clk_sys, resetn, cmd_valid, cmd_write, rst_req, cmd_ready, rsp_valid;
	logic host_port_select, reg_wr_en, cfg_default, serial_active, wr2_en;
	logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, reg_rd_data, reg_addr;
	logic [7:0] reg_wr_data, addr2, wdata2, a, d;
	logic [7:0] regs [256];
	logic [7:0] shadow [256];
	logic [7:0] q_rsp [$];
	logic [15:0] q_wr [$];
	logic [15:0] q_wr2 [$];
	int n_mismatch, checked, cycles, n;
	integer seed;
	logic [7:0] b_addr [3] = '{8'h00, 8'hff, 8'h80};
	logic [7:0] b_data [3] = '{8'hff, 8'h01, 8'h80};

	shp_if link ();
	shp_if link2 ();

	shp_host i_shp_host (.clk_sys(clk_sys), .resetn(resetn), .link(link),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rst_req(rst_req), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	shp_device i_shp_device (.clk_sys(clk_sys), .resetn(resetn), .link(link),
		.host_port_select(host_port_select), .reg_rd_data(reg_rd_data),
		.reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.cfg_default(cfg_default), .serial_active(serial_active));
	// second device end, driven by the bench to break the framing on purpose
	shp_device i_shp_device_2 (.clk_sys(clk_sys), .resetn(resetn),
		.link(link2), .host_port_select(host_port_select),
		.reg_rd_data(8'h5a), .reg_wr_en(wr2_en), .reg_addr(addr2),
		.reg_wr_data(wdata2), .cfg_default(), .serial_active());
	shp_link_sva i_shp_link_sva (.clk_sys(clk_sys), .resetn(resetn),
		.cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
		.rst_n_pin(link.rst_n_pin), .sdo_out(link.sdo_out),
		.sdo_oe(link.sdo_oe));

	// ==========================================
	// register file stand-in and result watcher
	assign reg_rd_data = regs[reg_addr];

	// outputs looked at on the falling edge, where they have settled
	always @(negedge clk_sys) begin
		cycles++;
		if (cfg_default === 1'b1)
			foreach (regs[i]) regs[i] <= 8'h00;
		else if (reg_wr_en === 1'b1)
			regs[reg_addr] <= reg_wr_data;
		if (rsp_valid === 1'b1)
			check("rsp_rdata", rsp_rdata, q_rsp.size() ? q_rsp.pop_front() : 'x);
		if (reg_wr_en === 1'b1) begin
			check("write", {reg_addr, reg_wr_data}, q_wr.size() ? q_wr.pop_front() : 'x);
			check("commit_cs_n", link.cs_n, 16'h0001);
		end
		if (wr2_en === 1'b1)
			check("write_2", {addr2, wdata2}, q_wr2.size() ? q_wr2.pop_front() : 'x);
		// ceiling well above the roughly 13000 cycles the scenarios need
		if (cycles == 40000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ==========================================
	// tasks
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// entered at a falling edge; holds the request over the taking rise
	task automatic cmd(input logic wr, input logic [7:0] ad, input logic [7:0] dt);
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = ad;
		cmd_wdata = dt;
		if (wr) begin
			shadow[ad] = dt;
			q_wr.push_back({ad, dt});
		end
		q_rsp.push_back(wr ? 8'h00 : shadow[ad]);
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask

	// bit-banged frame of n bits toward the second device, lsb first
	task automatic frame2(input logic [23:0] bits, input int nb);
		link2.sclk = 1'b1;
		repeat (10) @(negedge clk_sys);
		link2.sclk = 1'b0;
		link2.cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			link2.sdi = bits[i];
			repeat (10) @(negedge clk_sys);
			link2.sclk = 1'b1;
			repeat (10) @(negedge clk_sys);
			link2.sclk = 1'b0;
		end
		// released data line shows the inverse, not the last bit
		link2.sdi = ~link2.sdi;
		repeat (10) @(negedge clk_sys);
		link2.cs_n = 1'b1;
		repeat (30) @(negedge clk_sys);
	endtask

	// ==========================================
	// stimulus
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		seed = 32'hcf8a;
		resetn = 1'b0;
		{cmd_valid, cmd_write, rst_req, cmd_addr, cmd_wdata} = '0;
		host_port_select = 1'b1;
		{link2.cs_n, link2.sclk, link2.sdi, link2.rst_n_pin} = 4'h9;
		foreach (regs[i]) regs[i] = 8'h00;
		foreach (shadow[i]) shadow[i] = 8'h00;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		resetn = 1'b1;
		repeat (8) @(negedge clk_sys);
		check("serial_active", serial_active, 16'h0001);
		cmd(1'b0, 8'h55, 8'h00);
		foreach (b_addr[i]) cmd(1'b1, b_addr[i], b_data[i]);
		foreach (b_addr[i]) cmd(1'b0, b_addr[i], 8'h00);
		repeat (6) begin
			a = 8'($random(seed));
			d = 8'($random(seed));
			cmd(1'b1, a, d);
			cmd(1'b0, a, 8'($random(seed)));
		end
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		rst_req = 1'b1;
		@(negedge clk_sys);
		rst_req = 1'b0;
		while (link.rst_n_pin !== 1'b0) @(negedge clk_sys);
		for (n = 0; n < 1500 && cfg_default !== 1'b1; n++) @(negedge clk_sys);
		check("default_delay", n >= 1250 && n <= 1260, 16'h0001);
		foreach (shadow[i]) shadow[i] = 8'h00;
		cmd(1'b0, b_addr[0], 8'h00);
		frame2({8'h3c, 7'h7f, 1'b0, 8'ha5}, 23);
		q_wr2.push_back(16'ha53c);
		frame2({8'h3c, 7'h7f, 1'b0, 8'ha5}, 24);
		frame2({8'h77, 7'h55, 1'b1, 8'h11}, 24);
		check("sdo_float", {link2.sdo_oe, link2.sdo}, 16'h0001);
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		repeat (50) @(negedge clk_sys);
		// strap low across a fresh reset: the link must be ignored
		host_port_select = 1'b0;
		resetn = 1'b0;
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		repeat (8) @(negedge clk_sys);
		check("serial_off", serial_active, 16'h0000);
		frame2({8'h3c, 7'h00, 1'b0, 8'h5a}, 24);
		check("queues_left", q_rsp.size() + q_wr.size() + q_wr2.size(), 16'h0000);
		conclude();
	end
endmodule
`default_nettype wire
